/* File: aop_pkg.sv */
// Constants shared by the converter output port logic.
// Assumes a 125 MHz core clock; offsets are Avalon word indices.
package aop_pkg;
   localparam int CLK_NS = 8;
   localparam int WORD_W = 16;
   // Internal serial clock half period; least time, so round up
   localparam int SCLK_HALF_NS = 24;
   localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
   // Longest idle gap in fast mode; longest time, so round down
   localparam int MAX_IDLE_NS = 1000000;
   localparam int MAX_IDLE_CYC = MAX_IDLE_NS / CLK_NS;
   localparam logic [1:0] ADDR_CTRL = 2'h0;
   localparam logic [1:0] ADDR_STATUS = 2'h1;
   localparam logic [1:0] ADDR_RESULT = 2'h2;
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_CLR_BIT = 1;
   localparam logic CTRL_EN_RESET = 1'h1;
   localparam int ST_LOST_BIT = 7;
   localparam int ST_SBUSY_BIT = 8;
   localparam int ST_MACT_BIT = 9;
   // Configuration vector fields
   localparam int CFG_W = 7;
   localparam int CFG_OB = 0;
   localparam int CFG_FAST = 1;
   localparam int CFG_LP = 2;
   localparam int CFG_SER = 3;
   localparam int CFG_EXT = 4;
   localparam int CFG_SPOL = 5;
   localparam int CFG_CINV = 6;
   localparam int DATA_SDO_BIT = 8;
   localparam logic [4:0] BITS_FULL = 5'h10;
   typedef enum logic [3:0] {
      M_IDLE = 4'h1,
      M_LEAD = 4'h2,
      M_SHIFT = 4'h4,
      M_TAIL = 4'h8
   } aop_mst_e;
   // Offset binary when high, else MSB flipped to two's complement
   function automatic logic [15:0] code_word(input logic [15:0] w,
                                             input logic ob);
      code_word = ob ? w : {~w[15], w[14:0]};
   endfunction
endpackage

/* File: aop_link_shift.sv */
// Slave serial shifter running on the host-supplied serial clock.
// Assumes word is stable whenever req_tgl differs from ack_tgl.
module aop_link_shift import aop_pkg::*; (
   input wire logic link_clk,
   input wire logic rst_b,
   input wire logic req_tgl,
   input wire logic [15:0] word,
   output logic ack_tgl,
   output logic sdo
);
   logic [2:0] req_sync_reg;
   logic seen_reg;
   logic [15:0] sh_reg;
   logic [4:0] cnt_reg;
   logic load;

   // Change counts only once stages two and three agree
   assign load = (req_sync_reg[1] == req_sync_reg[2]) &&
                 (req_sync_reg[2] != seen_reg) && (cnt_reg == 5'h00);

   always_ff @(posedge link_clk or negedge rst_b) begin
      if (!rst_b) begin
         req_sync_reg <= 3'h0;
      end else begin
         req_sync_reg <= {req_sync_reg[1:0], req_tgl};
      end
   end

   // Active edge already folds in the inversion select
   always_ff @(posedge link_clk or negedge rst_b) begin
      if (!rst_b) begin
         seen_reg <= 1'h0;
         sh_reg <= 16'h0000;
         cnt_reg <= 5'h00;
         sdo <= 1'h0;
         ack_tgl <= 1'h0;
      end else if (load) begin
         seen_reg <= req_sync_reg[2];
         sdo <= word[15];
         sh_reg <= {word[14:0], 1'h0};
         cnt_reg <= BITS_FULL - 5'h01;
      end else if (cnt_reg != 5'h00) begin
         sdo <= sh_reg[15];
         sh_reg <= {sh_reg[14:0], 1'h0};
         cnt_reg <= cnt_reg - 5'h01;
         if (cnt_reg == 5'h01) begin
            ack_tgl <= seen_reg;
         end
      end
   end

   slave_shift_a: assert property (@(posedge link_clk) disable iff (!rst_b)
      cnt_reg != 5'h00 |=> sdo == $past(sh_reg[15]))
      else $error("slave data not shifted on active edge");
   slave_msb_a: assert property (@(posedge link_clk) disable iff (!rst_b)
      load |=> sdo == $past(word[15]) && cnt_reg == 5'h0F)
      else $error("slave frame does not start with msb");
   slave_frame_c: cover property (@(posedge link_clk) disable iff (!rst_b)
      cnt_reg == 5'h01 ##1 cnt_reg == 5'h00);
endmodule

/* File: aop_port.sv */
// Output port configuration for a 16-bit converter: coding, mode,
// parallel word and serial frames, with an Avalon-MM register slave.
// Assumes select pins are static between conversions; the serial clock
// pin may stop outside frames.
//
// Added by the designer: the Avalon-MM register port and the address map.

//Contract
//- Coding select high gives results in straight offset binary.
//- Coding select low flips the MSB for two's complement results.
//- Fast mode gives top rate; host must keep a minimum conversion rate.
//- Fast select low keeps accuracy however slow the conversions.
//- Low-power select alone gives power that scales with sample rate.
//- Serial/parallel select low delivers results on the parallel bus.
//- Serial/parallel select high uses the serial port on shared pins.
//- Data bits 0 to 3 are always driven as outputs.
//- Bits 4 to 6 drive result bits in parallel, are inputs in serial.
//- Serial with clock source low makes and drives the serial clock.
//- Serial with clock source high shifts data on the host's clock.
//- Frame sync is active high with polarity low, else active low.
//- Clock invert select inverts the serial clock in both modes.
//- Serial results are shifted out most significant bit first.
//- External clock: data updates on rising edge, or falling inverted.
module aop_port import aop_pkg::*; #(
   parameter int MAX_IDLE = MAX_IDLE_CYC
) (
   input wire logic CORE_CLK,
   input wire logic RST_B,
   input wire logic SCLK_IN,
   input wire logic [15:0] CONV_DATA,
   input wire logic CONV_START,
   input wire logic CONV_DONE,
   input wire logic OUTPUT_CODING_SELECT,
   input wire logic FAST_MODE_SELECT,
   input wire logic LOW_POWER_SELECT,
   input wire logic SERIAL_PARALLEL_SELECT,
   input wire logic [6:4] DATA_I,
   output logic [15:0] DATA_O,
   output logic [15:0] DATA_OE,
   output logic SCLK_O,
   output logic SCLK_OE,
   output logic SYNC_O,
   output logic MODE_FAST_O,
   output logic MODE_LOWPWR_O,
   output logic SLEEP_O,
   input wire logic [1:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST
);
   localparam logic [19:0] IDLE_LAST = 20'(MAX_IDLE - 1);
   localparam logic [1:0] HALF_LAST = 2'(SCLK_HALF_CYC - 1);

   logic [CFG_W-1:0] pins;
   logic [CFG_W-1:0] sync1_reg, sync2_reg, sync3_reg, cfg_reg;
   logic cfg_ob, cfg_fast, cfg_lp, cfg_ser, cfg_ext, cfg_spol, cfg_cinv;
   logic en_reg, lost_reg, conv_busy_reg;
   logic [19:0] idle_reg;
   logic [15:0] result_reg, par_reg, oe_reg, hold_reg, coded;
   logic wait_reg, req, clr;
   logic [31:0] rdata_reg;
   aop_mst_e mst_reg;
   logic [1:0] div_reg;
   logic [4:0] bits_reg;
   logic [15:0] sh_reg;
   logic ph_reg, sclk_reg, sclk_oe_reg, m_sdo_reg, sync_reg;
   logic m_start, half_end;
   logic req_tgl_reg, s_busy_reg, s_start;
   logic [2:0] ack_sync_reg;
   logic ack_tgl, s_sdo, link_clk;
   logic fast_mode, lp_mode;

   // Shared pins only carry selects while the serial port is on
   assign pins = {DATA_I[6], DATA_I[5], DATA_I[4], SERIAL_PARALLEL_SELECT,
                  LOW_POWER_SELECT, FAST_MODE_SELECT, OUTPUT_CODING_SELECT};
   assign cfg_ob = cfg_reg[CFG_OB];
   assign cfg_fast = cfg_reg[CFG_FAST];
   assign cfg_lp = cfg_reg[CFG_LP];
   assign cfg_ser = cfg_reg[CFG_SER];
   assign cfg_ext = cfg_reg[CFG_EXT] & cfg_ser;
   assign cfg_spol = cfg_reg[CFG_SPOL] & cfg_ser;
   assign cfg_cinv = cfg_reg[CFG_CINV] & cfg_ser;
   assign fast_mode = cfg_fast & ~cfg_lp;
   assign lp_mode = cfg_lp & ~cfg_fast;
   assign coded = code_word(CONV_DATA, cfg_ob);

   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
         sync3_reg <= '0;
      end else begin
         sync1_reg <= pins;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
      end
   end

   // Filtered config; a select glitch seen in a single sample never reaches cfg_reg
   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         cfg_reg <= '0;
      end else if (sync2_reg == sync3_reg) begin
         cfg_reg <= sync3_reg;
      end
   end

   // Avalon slave: waitrequest drops one cycle after the request
   assign req = AVS_READ | AVS_WRITE;
   assign clr = AVS_WRITE && !wait_reg && AVS_ADDRESS == ADDR_CTRL &&
                AVS_WRITEDATA[CTRL_CLR_BIT];

   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         wait_reg <= 1'h1;
      end else begin
         wait_reg <= !(req && wait_reg);
      end
   end

   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         rdata_reg <= 32'h00000000;
      end else if (AVS_READ && wait_reg) begin
         case (AVS_ADDRESS)
            ADDR_CTRL: rdata_reg <= {31'h0, en_reg};
            ADDR_STATUS: rdata_reg <= {22'h0, mst_reg != M_IDLE, s_busy_reg,
                                       lost_reg, cfg_reg};
            ADDR_RESULT: rdata_reg <= {16'h0, result_reg};
            default: rdata_reg <= 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         en_reg <= CTRL_EN_RESET;
      end else if (AVS_WRITE && !wait_reg && AVS_ADDRESS == ADDR_CTRL) begin
         en_reg <= AVS_WRITEDATA[CTRL_EN_BIT];
      end
   end

   // Fast mode loses accuracy after a long gap; flag it, set beats clear
   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         idle_reg <= 20'h00000;
         lost_reg <= 1'h0;
      end else begin
         if (!fast_mode || CONV_DONE) begin
            idle_reg <= 20'h00000;
         end else if (idle_reg != IDLE_LAST) begin
            idle_reg <= idle_reg + 20'h00001;
         end
         if (fast_mode && !CONV_DONE && idle_reg == IDLE_LAST) begin
            lost_reg <= 1'h1;
         end else if (clr) begin
            lost_reg <= 1'h0;
         end
      end
   end

   // Converter mode lines and low-power sleep between conversions
   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         conv_busy_reg <= 1'h0;
         MODE_FAST_O <= 1'h0;
         MODE_LOWPWR_O <= 1'h0;
         SLEEP_O <= 1'h0;
      end else begin
         if (CONV_START) begin
            conv_busy_reg <= 1'h1;
         end else if (CONV_DONE) begin
            conv_busy_reg <= 1'h0;
         end
         MODE_FAST_O <= fast_mode;
         MODE_LOWPWR_O <= lp_mode;
         SLEEP_O <= lp_mode && !conv_busy_reg && !CONV_START;
      end
   end

   // Result capture and parallel word; port updates can be frozen
   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         result_reg <= 16'h0000;
         par_reg <= 16'h0000;
      end else if (CONV_DONE) begin
         result_reg <= coded;
         if (en_reg) begin
            par_reg <= coded;
         end
      end
   end

   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         oe_reg <= 16'h000F;
      end else if (cfg_ser) begin
         oe_reg <= 16'hFF0F;
      end else begin
         oe_reg <= 16'hFFFF;
      end
   end

   // Internal clock master: lead half period, 16 bits, tail
   assign m_start = CONV_DONE && en_reg && cfg_ser && !cfg_ext &&
                    mst_reg == M_IDLE;
   assign half_end = div_reg == HALF_LAST;

   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         mst_reg <= M_IDLE;
         div_reg <= 2'h0;
         bits_reg <= 5'h00;
         sh_reg <= 16'h0000;
         ph_reg <= 1'h0;
         m_sdo_reg <= 1'h0;
      end else begin
         div_reg <= (mst_reg == M_IDLE || half_end) ? 2'h0 : div_reg + 2'h1;
         case (mst_reg)
            M_IDLE: begin
               ph_reg <= 1'h0;
               if (m_start) begin
                  m_sdo_reg <= coded[15];
                  sh_reg <= {coded[14:0], 1'h0};
                  bits_reg <= BITS_FULL;
                  mst_reg <= M_LEAD;
               end
            end
            M_LEAD: begin
               if (half_end) begin
                  mst_reg <= M_SHIFT;
               end
            end
            M_SHIFT: begin
               if (half_end) begin
                  ph_reg <= !ph_reg;
                  if (!ph_reg) begin
                     bits_reg <= bits_reg - 5'h01;
                  end else if (bits_reg == 5'h00) begin
                     mst_reg <= M_TAIL;
                  end else begin
                     m_sdo_reg <= sh_reg[15];
                     sh_reg <= {sh_reg[14:0], 1'h0};
                  end
               end
            end
            M_TAIL: begin
               if (half_end) begin
                  mst_reg <= M_IDLE;
               end
            end
            default: mst_reg <= M_IDLE;
         endcase
      end
   end

   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         sclk_reg <= 1'h0;
         sclk_oe_reg <= 1'h0;
      end else begin
         sclk_reg <= ph_reg ^ cfg_cinv;
         sclk_oe_reg <= cfg_ser && !cfg_ext;
      end
   end

   // Slave path: word crosses by toggle handshake into the link domain
   assign s_start = CONV_DONE && en_reg && cfg_ext && !s_busy_reg;

   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         ack_sync_reg <= 3'h0;
      end else begin
         ack_sync_reg <= {ack_sync_reg[1:0], ack_tgl};
      end
   end

   // A result arriving mid-frame is dropped; hold_reg must stay put
   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         hold_reg <= 16'h0000;
         req_tgl_reg <= 1'h0;
         s_busy_reg <= 1'h0;
      end else if (s_start) begin
         hold_reg <= coded;
         req_tgl_reg <= !req_tgl_reg;
         s_busy_reg <= 1'h1;
      end else if (ack_sync_reg[1] == ack_sync_reg[2] &&
                   ack_sync_reg[2] == req_tgl_reg) begin
         s_busy_reg <= 1'h0;
      end
   end

   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         sync_reg <= 1'h0;
      end else begin
         sync_reg <= (mst_reg != M_IDLE || s_busy_reg) ^ cfg_spol;
      end
   end

   // Static select picks the active edge; changed only between frames
   assign link_clk = SCLK_IN ^ DATA_I[6];

   aop_link_shift u_link (
      .link_clk(link_clk),
      .rst_b(RST_B),
      .req_tgl(req_tgl_reg),
      .word(hold_reg),
      .ack_tgl(ack_tgl),
      .sdo(s_sdo)
   );

   // Bit 8 picks among three flops by static selects
   assign DATA_O = {par_reg[15:9],
                    cfg_ser ? (cfg_ext ? s_sdo : m_sdo_reg)
                            : par_reg[DATA_SDO_BIT],
                    par_reg[7:0]};
   assign DATA_OE = oe_reg;
   assign SCLK_O = sclk_reg;
   assign SCLK_OE = sclk_oe_reg;
   assign SYNC_O = sync_reg;
   assign AVS_READDATA = rdata_reg;
   assign AVS_WAITREQUEST = wait_reg;

   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RST_B);

   code_ob_a: assert property (CONV_DONE && cfg_ob |=>
      result_reg == $past(CONV_DATA))
      else $error("offset binary result altered");
   code_2c_a: assert property (CONV_DONE && !cfg_ob |=>
      result_reg == {~$past(CONV_DATA[15]), $past(CONV_DATA[14:0])})
      else $error("two's complement msb not flipped");
   fast_lost_a: assert property (fast_mode && !CONV_DONE &&
      idle_reg == IDLE_LAST |=> lost_reg)
      else $error("fast mode idle gap not flagged");
   normal_idle_a: assert property (!fast_mode |=> idle_reg == 20'h0)
      else $error("idle counted outside fast mode");
   lp_sleep_a: assert property (lp_mode && !conv_busy_reg &&
      !CONV_START ##1 lp_mode |-> SLEEP_O)
      else $error("low power mode did not sleep when idle");
   par_bus_a: assert property (!cfg_ser |=> DATA_OE == 16'hFFFF)
      else $error("parallel bus not fully driven");
   ser_pins_a: assert property (cfg_ser |=> DATA_OE[7:4] == 4'h0)
      else $error("shared select pins still driven");
   low_bits_a: assert property (DATA_OE[3:0] == 4'hF)
      else $error("low data bits not driven");
   int_clk_a: assert property (cfg_ser && !cfg_ext |=> SCLK_OE)
      else $error("internal serial clock not driven");
   ext_clk_a: assert property (cfg_ext |=> !SCLK_OE)
      else $error("serial clock driven in external mode");
   sync_pol_a: assert property (mst_reg == M_IDLE && !s_busy_reg
      ##1 $stable(cfg_spol) |-> SYNC_O == cfg_spol)
      else $error("idle frame sync has wrong polarity");
   clk_inv_a: assert property (mst_reg == M_IDLE ##1
      $stable(cfg_cinv) |-> SCLK_O == cfg_cinv)
      else $error("idle serial clock level not inverted");
   msb_first_a: assert property (m_start |=>
      m_sdo_reg == $past(coded[15]) && mst_reg == M_LEAD)
      else $error("master frame does not start with msb");
   bits_a: assert property (mst_reg == M_SHIFT && half_end &&
      ph_reg && bits_reg != 5'h0 |=> m_sdo_reg == $past(sh_reg[15]))
      else $error("master bit not advanced on falling edge");

   par_word_c: cover property (CONV_DONE && !cfg_ser ##1 DATA_OE == 16'hFFFF);
   master_frame_c: cover property (mst_reg == M_TAIL ##1 mst_reg == M_IDLE);
   slave_done_c: cover property ($fell(s_busy_reg));
   lost_c: cover property ($rose(lost_reg));
endmodule

/* File: aop_host_model.sv */
// Host side of the serial link: clocks frames in slave mode, captures
// serial data in both modes. Assumes the bench resolves the clock pin.
module aop_host_model (
   input wire logic ext,
   input wire logic cinv,
   input wire logic spol,
   input wire logic sync,
   input wire logic sclk_wire,
   input wire logic sdo,
   output logic sclk_drv,
   output logic [63:0] hist,
   output int nbits
);
   timeunit 1ns;
   timeprecision 100ps;
   logic frame;
   logic v;
   assign frame = sync ^ spol;
   assign v = sclk_wire ^ cinv;
   // Clock stands still outside frames, as a real host would leave it
   initial begin
      sclk_drv = 1'b0;
      forever begin
         #24;
         if (ext && frame) begin
            sclk_drv = ~sclk_drv;
         end else begin
            sclk_drv = 1'b0;
         end
      end
   end
   initial begin
      hist = '0;
      nbits = 0;
   end
   // Opposite edge to the update edge, where data must be valid
   always @(negedge v) begin
      if (ext && frame) begin
         hist = {hist[62:0], sdo};
         nbits++;
      end
   end
   // Internal clock: data stays put across the rising edge
   always @(posedge v) begin
      if (!ext && frame) begin
         hist = {hist[62:0], sdo};
         nbits++;
      end
   end
endmodule

/* File: test_adc_output_port_config.sv */
// Self-checking bench for the converter output port configuration.
// Assumes the host model above; shared pins are resolved here.
module test_adc_output_port_config import aop_pkg::*; ;
   timeunit 1ns;
   timeprecision 100ps;
   logic CORE_CLK, RST_B, CONV_START, CONV_DONE;
   logic [15:0] CONV_DATA, DATA_O, DATA_OE;
   logic SCLK_O, SCLK_OE, SYNC_O, MODE_FAST_O, MODE_LOWPWR_O, SLEEP_O;
   logic AVS_READ, AVS_WRITE, AVS_WAITREQUEST;
   logic [1:0] AVS_ADDRESS;
   logic [31:0] AVS_WRITEDATA, AVS_READDATA, q;
   logic ob, fast, lp, ser, ext, spol, cinv, sclk_drv, sclk_wire;
   logic [6:4] data_i;
   logic [63:0] hist;
   logic [15:0] wv, e;
   int nbits, n0, err_total, checks;
   assign sclk_wire = SCLK_OE ? SCLK_O : sclk_drv;
   assign data_i = (DATA_O[6:4] & DATA_OE[6:4])
      | ({cinv, spol, ext} & ~DATA_OE[6:4]);
   aop_port #(.MAX_IDLE(50)) aop_port_i (.CORE_CLK(CORE_CLK), .RST_B(RST_B),
      .SCLK_IN(sclk_wire), .CONV_DATA(CONV_DATA), .CONV_START(CONV_START),
      .CONV_DONE(CONV_DONE), .OUTPUT_CODING_SELECT(ob),
      .FAST_MODE_SELECT(fast), .LOW_POWER_SELECT(lp),
      .SERIAL_PARALLEL_SELECT(ser), .DATA_I(data_i), .DATA_O(DATA_O),
      .DATA_OE(DATA_OE), .SCLK_O(SCLK_O), .SCLK_OE(SCLK_OE),
      .SYNC_O(SYNC_O), .MODE_FAST_O(MODE_FAST_O),
      .MODE_LOWPWR_O(MODE_LOWPWR_O), .SLEEP_O(SLEEP_O),
      .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
      .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
      .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST));
   aop_host_model aop_host_model_i (.ext(ext), .cinv(cinv), .spol(spol),
      .sync(SYNC_O), .sclk_wire(sclk_wire), .sdo(DATA_O[8]),
      .sclk_drv(sclk_drv), .hist(hist), .nbits(nbits));
   initial begin
      CORE_CLK = 1'b0;
      forever #4 CORE_CLK = ~CORE_CLK;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Ends mid-cycle, where outputs launched at the edge have settled
   task automatic tick(input int n);
      repeat (n) @(posedge CORE_CLK);
      @(negedge CORE_CLK);
   endtask
   // Order {cinv, spol, ext, ser, lp, fast, ob}; shared pins reach the
   // filter only after the enables turn around, so allow two passes
   task automatic setcfg(input logic [6:0] c);
      @(posedge CORE_CLK);
      {cinv, spol, ext, ser, lp, fast, ob} <= c;
      tick(12);
   endtask
   // No wait count assumed; only the watchdog ends a hang
   task automatic bus(input logic wr, input logic [1:0] a,
                      input logic [31:0] d, output logic [31:0] r);
      @(posedge CORE_CLK);
      AVS_ADDRESS <= a;
      AVS_WRITEDATA <= d;
      AVS_WRITE <= wr;
      AVS_READ <= ~wr;
      do begin
         @(posedge CORE_CLK);
      end while (AVS_WAITREQUEST !== 1'b0);
      r = AVS_READDATA;
      AVS_READ <= 1'b0;
      AVS_WRITE <= 1'b0;
   endtask
   task automatic conv(input logic [15:0] w);
      @(posedge CORE_CLK);
      CONV_START <= 1'b1;
      @(posedge CORE_CLK);
      CONV_START <= 1'b0;
      CONV_DATA <= w;
      CONV_DONE <= 1'b1;
      @(posedge CORE_CLK);
      CONV_DONE <= 1'b0;
   endtask
   // Bounded wait for a frame to open and then close again
   task automatic frame_end();
      int n;
      n = 0;
      while ((SYNC_O ^ spol) !== 1'b1 && n < 20) begin
         tick(1);
         n++;
      end
      if (n >= 20) err_total++;
      while ((SYNC_O ^ spol) !== 1'b0 && n < 400) begin
         tick(1);
         n++;
      end
      if (n >= 400) err_total++;
      tick(2);
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      #200000;
      err_total++;
      complete_run();
   end
   initial begin
      {RST_B, CONV_START, CONV_DONE, AVS_READ, AVS_WRITE} = '0;
      CONV_DATA = '0;
      AVS_ADDRESS = '0;
      AVS_WRITEDATA = '0;
      {cinv, spol, ext, ser, lp, fast, ob} = 7'h01;
      err_total = 0;
      checks = 0;
      tick(4);
      chk(DATA_OE, 32'h000F);
      repeat (4) @(posedge CORE_CLK);
      RST_B <= 1'b1;
      tick(6);
      chk(DATA_OE, 32'hFFFF);
      $display("test reset done");
      for (int i = 0; i < 2; i++) begin
         setcfg({6'h00, i[0]});
         wv = 16'h8A5C;
         e = i[0] ? wv : {~wv[15], wv[14:0]};
         conv(wv);
         tick(2);
         chk(DATA_O, e);
         bus(1'b0, ADDR_RESULT, 32'h0, q);
         chk(q[15:0], e);
      end
      bus(1'b0, 2'h3, 32'h0, q);
      chk(q, 32'h0);
      // Port disabled: result register moves, parallel word stays
      bus(1'b1, ADDR_CTRL, 32'h0, q);
      conv(16'h1234);
      tick(2);
      chk(DATA_O, e);
      bus(1'b0, ADDR_RESULT, 32'h0, q);
      chk(q[15:0], 16'h1234);
      bus(1'b0, ADDR_CTRL, 32'h0, q);
      chk(q, 32'h0);
      bus(1'b1, ADDR_CTRL, 32'h1, q);
      $display("test coding done");
      for (int i = 0; i < 4; i++) begin
         setcfg({4'h0, i[1:0], 1'b1});
         chk(MODE_FAST_O, i == 1);
         chk(MODE_LOWPWR_O, i == 2);
         chk(SLEEP_O, i == 2);
      end
      // Idle gap flag: set in fast mode only, cleared by a control write
      setcfg(7'h03);
      bus(1'b1, ADDR_CTRL, 32'h3, q);
      tick(60);
      bus(1'b0, ADDR_STATUS, 32'h0, q);
      chk(q[ST_LOST_BIT], 1'b1);
      setcfg(7'h01);
      bus(1'b1, ADDR_CTRL, 32'h3, q);
      tick(60);
      bus(1'b0, ADDR_STATUS, 32'h0, q);
      chk(q[ST_LOST_BIT], 1'b0);
      $display("test modes done");
      for (int i = 0; i < 4; i++) begin
         setcfg({i[1:0], 5'h09});
         chk(DATA_OE, 32'hFF0F);
         chk(SCLK_OE, 1'b1);
         chk(SCLK_O, cinv);
         chk(SYNC_O, spol);
         n0 = nbits;
         wv = {i[1:0], 14'h2D69};
         conv(wv);
         frame_end();
         chk(hist[15:0], wv);
         chk(nbits - n0, 32'd16);
      end
      bus(1'b0, ADDR_STATUS, 32'h0, q);
      chk(q[6:0], {cinv, spol, ext, ser, lp, fast, ob});
      $display("test serial internal done");
      for (int i = 0; i < 4; i++) begin
         setcfg({i[1:0], 5'h19});
         chk(SCLK_OE, 1'b0);
         wv = {2'h1, i[1:0], 12'h9B6};
         conv(wv);
         frame_end();
         // Host clock halts once the frame closes: last bit is newest
         chk(hist[15:0], wv);
      end
      $display("test serial external done");
      complete_run();
   end
endmodule
